// *** shared/flash_cmd_pkg.sv ***
// Constants shared by the serial flash status and read command decoder
package flash_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
    localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h35;
    localparam logic [7:0] CMD_READ_STATUS_THREE = 8'h15;
    localparam logic [7:0] CMD_WRITE_STATUS_ONE = 8'h01;
    localparam logic [7:0] CMD_WRITE_STATUS_TWO = 8'h31;
    localparam logic [7:0] CMD_WRITE_STATUS_THREE = 8'h11;
    localparam logic [7:0] CMD_READ_ARRAY = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // Status register field positions
    localparam int BUSY_BIT = 0;
    localparam int WRITE_LATCH_BIT = 1;
    localparam int REGISTER_LOCK_BIT = 0;
    localparam int QUAD_ENABLE_BIT = 1;

    // Writable fields: protect, sector, top-bottom, block-protect
    localparam logic [7:0] ONE_WRITABLE = 8'hfc;
    // Writable fields: complement, security locks, quad enable, lock
    localparam logic [7:0] TWO_WRITABLE = 8'h7b;
    // Writable fields: hold-reset, drive strength, protect scheme
    localparam logic [7:0] THREE_WRITABLE = 8'he4;
    localparam logic [7:0] SECURITY_LOCK_MASK = 8'h38;
    localparam logic [7:0] REGISTER_LOCK_MASK = 8'h01;
    localparam logic [7:0] QUAD_ENABLE_MASK = 8'h02;

    ////////////////////////////////////////////////////////////////////////
    // Reset values of the stored status bits
    localparam logic [7:0] ONE_RESET = 8'h00;
    localparam logic [7:0] TWO_RESET = 8'h00;
    localparam logic [7:0] THREE_RESET = 8'h60;

    ////////////////////////////////////////////////////////////////////////
    // Framing
    localparam int ADDR_WIDTH = 24;
    localparam logic [2:0] BYTE_COUNT_MAX = 3'd7;
    localparam logic [2:0] DATA_PHASE_BYTES = 3'd4;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int STATUS_WRITE_TIME_NS = 10000000;
    localparam int STATUS_WRITE_CYCLES =
        (STATUS_WRITE_TIME_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
        STATUS_WRITE_TIME_NS / CLOCK_PERIOD_NS;

endpackage : flash_cmd_pkg

// *** hdl/flash_status_read_cmds.sv ***
// Serial flash command decoder: write latch, status registers, basic read
`timescale 1ns/1ps
`default_nettype none

module flash_status_read_cmds #(
    parameter int WRITE_CYCLES = flash_cmd_pkg::STATUS_WRITE_CYCLES,
    parameter int ARRAY_ADDR_WIDTH = flash_cmd_pkg::ADDR_WIDTH
) (
    // System clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Device control
    input wire logic soft_reset,
    input wire logic four_wire_command_mode,
    // Serial link
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // Memory array read port, link clock domain
    output logic [ARRAY_ADDR_WIDTH-1:0] array_addr,
    input wire logic [7:0] array_data,
    // Status view
    output logic [7:0] status_reg_one,
    output logic [7:0] status_reg_two,
    output logic [7:0] status_reg_three
);

    if (WRITE_CYCLES < 1) begin : g_bad_cycles
        $error("WRITE_CYCLES must be at least one");
    end
    if (ARRAY_ADDR_WIDTH < 1 || ARRAY_ADDR_WIDTH > 24) begin : g_bad_addr
        $error("ARRAY_ADDR_WIDTH must lie between 1 and 24");
    end

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    function automatic logic [7:0] merge_bits(input logic [7:0] old,
                                              input logic [7:0] data,
                                              input logic [7:0] mask,
                                              input logic [7:0] keep);
        merge_bits = (old & ~mask) | (data & mask) | (old & keep);
    endfunction : merge_bits

    function automatic logic is_status_read(input logic [7:0] code);
        is_status_read = code == flash_cmd_pkg::CMD_READ_STATUS_ONE ||
                         code == flash_cmd_pkg::CMD_READ_STATUS_TWO ||
                         code == flash_cmd_pkg::CMD_READ_STATUS_THREE;
    endfunction : is_status_read

    ////////////////////////////////////////////////////////////////////////
    // Link domain: status and mode brought over by two flip-flops
    logic [23:0] stat_meta_q;
    logic [23:0] stat_link_q;
    logic qpi_meta_q;
    logic qpi_link_q;

    always_ff @(posedge link_clk) begin
        stat_meta_q <= {status_reg_three, status_reg_two, status_reg_one};
        stat_link_q <= stat_meta_q;
        qpi_meta_q <= four_wire_command_mode;
        qpi_link_q <= qpi_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: input shifting, cleared whenever chip select is high
    logic [2:0] bits_q;
    logic [2:0] nbytes_q;
    logic [7:0] shift_q;
    logic [2:0] bits_d;
    logic [2:0] nbytes_d;
    logic [7:0] byte_now;
    logic byte_done;
    logic rd_stat_q;
    logic rd_arr_q;
    logic [1:0] stat_sel_q;
    logic [23:0] addr_q;

    always_comb begin
        if (qpi_link_q) begin
            bits_d = bits_q + 3'd4;
            byte_now = {shift_q[3:0], io_in};
        end else begin
            bits_d = bits_q + 3'd1;
            byte_now = {shift_q[6:0], io_in[0]};
        end
        byte_done = bits_d == 3'd0;
        if (byte_done && nbytes_q != flash_cmd_pkg::BYTE_COUNT_MAX) begin
            nbytes_d = nbytes_q + 3'd1;
        end else begin
            nbytes_d = nbytes_q;
        end
    end

    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            bits_q <= 3'd0;
            nbytes_q <= 3'd0;
            shift_q <= 8'h00;
        end else begin
            bits_q <= bits_d;
            nbytes_q <= nbytes_d;
            shift_q <= byte_now;
        end
    end

    // Command decode at the end of the first byte
    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            rd_stat_q <= 1'b0;
            rd_arr_q <= 1'b0;
            stat_sel_q <= 2'd0;
        end else if (byte_done && nbytes_q == 3'd0) begin
            rd_stat_q <= is_status_read(byte_now);
            rd_arr_q <= byte_now == flash_cmd_pkg::CMD_READ_ARRAY &&
                        !qpi_link_q &&
                        !stat_link_q[flash_cmd_pkg::BUSY_BIT];
            if (byte_now == flash_cmd_pkg::CMD_READ_STATUS_TWO) begin
                stat_sel_q <= 2'd1;
            end else if (byte_now == flash_cmd_pkg::CMD_READ_STATUS_THREE)
            begin
                stat_sel_q <= 2'd2;
            end else begin
                stat_sel_q <= 2'd0;
            end
        end
    end

    // Address gathering and auto increment
    always_ff @(posedge link_clk) begin
        if (byte_done) begin
            unique case (nbytes_q)
                3'd1: addr_q[23:16] <= byte_now;
                3'd2: addr_q[15:8] <= byte_now;
                3'd3: addr_q[7:0] <= byte_now;
                3'd0: addr_q <= addr_q;
                default: addr_q <= addr_q + 24'h000001;
            endcase
        end
    end

    assign array_addr = addr_q[ARRAY_ADDR_WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame record, held still once the link clock stops
    logic [7:0] fr_cmd_q;
    logic [7:0] fr_d1_q;
    logic [7:0] fr_d2_q;
    logic [2:0] fr_cnt_q;
    logic fr_odd_q;

    always_ff @(posedge link_clk) begin
        fr_cnt_q <= nbytes_d;
        fr_odd_q <= !byte_done;
        if (byte_done) begin
            unique case (nbytes_q)
                3'd0: fr_cmd_q <= byte_now;
                3'd1: fr_d1_q <= byte_now;
                3'd2: fr_d2_q <= byte_now;
                default: fr_cmd_q <= fr_cmd_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: output on falling edges
    logic [7:0] src_byte;
    logic [3:0] out_q;
    logic [3:0] oe_q;

    always_comb begin
        if (rd_stat_q) begin
            unique case (stat_sel_q)
                2'd1: src_byte = stat_link_q[15:8];
                2'd2: src_byte = stat_link_q[23:16];
                default: src_byte = stat_link_q[7:0];
            endcase
        end else begin
            src_byte = array_data;
        end
    end

    always_ff @(negedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            out_q <= 4'h0;
            oe_q <= 4'h0;
        end else if (rd_stat_q && qpi_link_q) begin
            out_q <= bits_q[2] ? src_byte[3:0] : src_byte[7:4];
            oe_q <= 4'hf;
        end else if (rd_stat_q ||
                     (rd_arr_q && nbytes_q >= flash_cmd_pkg::DATA_PHASE_BYTES))
        begin
            out_q <= {2'b00, src_byte[3'd7 - bits_q], 1'b0};
            oe_q <= 4'h2;
        end else begin
            out_q <= 4'h0;
            oe_q <= 4'h0;
        end
    end

    assign io_out = out_q;
    assign io_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // System domain: chip select synchroniser and frame end
    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    logic frame_end;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cs_meta_q <= cs_n;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    assign frame_end = cs_sync_q && !cs_prev_q && !fr_odd_q &&
                       fr_cnt_q != 3'd0;

    ////////////////////////////////////////////////////////////////////////
    // System domain: command execution
    logic [7:0] one_q;
    logic [7:0] two_q;
    logic [7:0] three_q;
    logic [7:0] one_nv_q;
    logic [7:0] two_nv_q;
    logic [7:0] three_nv_q;
    logic [7:0] pend_one_q;
    logic [7:0] pend_two_q;
    logic [7:0] pend_three_q;
    logic wel_q;
    logic vol_q;
    logic busy_q;
    logic [CNT_W-1:0] busy_cnt_q;
    logic is_ws;
    logic cmd_single;
    logic nv_go;
    logic vol_go;
    logic write_done;
    logic [7:0] base_one;
    logic [7:0] base_two;
    logic [7:0] base_three;
    logic [7:0] new_one;
    logic [7:0] new_two;
    logic [7:0] new_three;
    logic [7:0] two_mask;
    logic [7:0] two_keep;

    always_comb begin
        cmd_single = frame_end && fr_cnt_q == 3'd1;
        is_ws = frame_end && fr_cnt_q >= 3'd2 &&
                (fr_cmd_q == flash_cmd_pkg::CMD_WRITE_STATUS_ONE ||
                 fr_cmd_q == flash_cmd_pkg::CMD_WRITE_STATUS_TWO ||
                 fr_cmd_q == flash_cmd_pkg::CMD_WRITE_STATUS_THREE);
        nv_go = is_ws && wel_q && !busy_q;
        vol_go = is_ws && !wel_q && vol_q && !busy_q;
        write_done = busy_q && busy_cnt_q == '0;
        base_one = vol_go ? one_q : one_nv_q;
        base_two = vol_go ? two_q : two_nv_q;
        base_three = vol_go ? three_q : three_nv_q;
        two_mask = flash_cmd_pkg::TWO_WRITABLE &
                   ~(four_wire_command_mode ?
                     flash_cmd_pkg::QUAD_ENABLE_MASK : 8'h00);
        two_keep = flash_cmd_pkg::SECURITY_LOCK_MASK |
                   (vol_go ? flash_cmd_pkg::REGISTER_LOCK_MASK : 8'h00);
        new_one = base_one;
        new_two = base_two;
        new_three = base_three;
        if (fr_cmd_q == flash_cmd_pkg::CMD_WRITE_STATUS_ONE) begin
            new_one = merge_bits(base_one, fr_d1_q,
                                 flash_cmd_pkg::ONE_WRITABLE, 8'h00);
            if (fr_cnt_q >= 3'd3) begin
                new_two = merge_bits(base_two, fr_d2_q, two_mask,
                                     two_keep);
            end
        end else if (fr_cmd_q == flash_cmd_pkg::CMD_WRITE_STATUS_TWO) begin
            new_two = merge_bits(base_two, fr_d1_q, two_mask, two_keep);
        end else begin
            new_three = merge_bits(base_three, fr_d1_q,
                                   flash_cmd_pkg::THREE_WRITABLE, 8'h00);
        end
    end

    // Stored values and the timed write cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            one_nv_q <= flash_cmd_pkg::ONE_RESET;
            two_nv_q <= flash_cmd_pkg::TWO_RESET;
            three_nv_q <= flash_cmd_pkg::THREE_RESET;
            pend_one_q <= flash_cmd_pkg::ONE_RESET;
            pend_two_q <= flash_cmd_pkg::TWO_RESET;
            pend_three_q <= flash_cmd_pkg::THREE_RESET;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
        end else if (nv_go) begin
            pend_one_q <= new_one;
            pend_two_q <= new_two;
            pend_three_q <= new_three;
            busy_q <= 1'b1;
            busy_cnt_q <= CNT_W'(WRITE_CYCLES - 1);
        end else if (write_done) begin
            one_nv_q <= pend_one_q;
            two_nv_q <= pend_two_q;
            three_nv_q <= pend_three_q;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - CNT_W'(1);
        end
    end

    // Working status values seen by the rest of the device
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            one_q <= flash_cmd_pkg::ONE_RESET;
            two_q <= flash_cmd_pkg::TWO_RESET;
            three_q <= flash_cmd_pkg::THREE_RESET;
        end else if (write_done) begin
            one_q <= pend_one_q;
            two_q <= pend_two_q;
            three_q <= pend_three_q;
        end else if (soft_reset) begin
            one_q <= one_nv_q;
            two_q <= two_nv_q;
            three_q <= three_nv_q;
        end else if (vol_go) begin
            one_q <= new_one;
            two_q <= new_two;
            three_q <= new_three;
        end
    end

    // Write latch; a completion wins over a command arriving with it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wel_q <= 1'b0;
        end else if (cmd_single && !busy_q &&
                     fr_cmd_q == flash_cmd_pkg::CMD_WRITE_ENABLE) begin
            wel_q <= 1'b1;
        end else if (soft_reset || write_done) begin
            wel_q <= 1'b0;
        end else if (cmd_single &&
                     fr_cmd_q == flash_cmd_pkg::CMD_WRITE_DISABLE) begin
            wel_q <= 1'b0;
        end
    end

    // Volatile write permission, consumed by the next command other than a status read
    always_ff @(posedge clock) begin
        if (sys_rst || soft_reset) begin
            vol_q <= 1'b0;
        end else if (frame_end && !is_status_read(fr_cmd_q)) begin
            vol_q <= cmd_single &&
                     fr_cmd_q == flash_cmd_pkg::CMD_VOLATILE_ENABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status view
    always_comb begin
        status_reg_one = one_q;
        status_reg_one[flash_cmd_pkg::BUSY_BIT] = busy_q;
        status_reg_one[flash_cmd_pkg::WRITE_LATCH_BIT] = wel_q;
        status_reg_two = two_q;
        status_reg_three = three_q;
    end

endmodule : flash_status_read_cmds

`default_nettype wire

// *** testbench/flash_cmds_checker.sv ***
// Assertion checker for the status and read command decoder
`timescale 1ns/1ps
`default_nettype none
module flash_cmds_checker #(
    parameter int WRITE_CYCLES = 20,
    parameter int ARRAY_ADDR_WIDTH = 24
) (
    // System side
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic soft_reset,
    input wire logic four_wire_command_mode,
    // Serial link
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    // Array port and status view
    input wire logic [ARRAY_ADDR_WIDTH-1:0] array_addr,
    input wire logic [7:0] array_data,
    input wire logic [7:0] status_reg_one,
    input wire logic [7:0] status_reg_two,
    input wire logic [7:0] status_reg_three
);
    logic [31:0] busy_cnt_q;
    logic [5:0] edge_cnt_q;
    always_ff @(posedge clock) begin
        if (sys_rst || !status_reg_one[0]) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt_q <= '0;
        end else if (edge_cnt_q != 6'h3f) begin
            edge_cnt_q <= edge_cnt_q + 6'h1;
        end
    end
    sequence busy_end;
        $fell(status_reg_one[0]);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_OE_IDLE: assert property (
        @(posedge clock) disable iff (sys_rst)
        cs_n && $past(cs_n) |-> io_oe == 4'h0)
        else $error("output enabled while deselected");
    AST_OE_SINGLE: assert property (
        @(posedge link_clk) disable iff (cs_n)
        !four_wire_command_mode && io_oe != 4'h0 |-> io_oe == 4'h2)
        else $error("wrong output lines in single-line mode");
    AST_NO_EARLY_OUT: assert property (
        @(posedge link_clk) disable iff (cs_n)
        !four_wire_command_mode && edge_cnt_q < 6'd8 |-> io_oe == 4'h0)
        else $error("output before command byte complete");
    AST_BUSY_NEEDS_LATCH: assert property (
        @(posedge clock) disable iff (sys_rst)
        $rose(status_reg_one[0]) |-> status_reg_one[1] && cs_n)
        else $error("busy started without write latch");
    AST_BUSY_LEN: assert property (
        @(posedge clock) disable iff (sys_rst)
        busy_end |-> busy_cnt_q >= WRITE_CYCLES - 1 &&
        busy_cnt_q <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    AST_LATCH_CLR: assert property (
        @(posedge clock) disable iff (sys_rst)
        busy_end |-> !status_reg_one[1])
        else $error("write latch kept after write cycle");
    AST_LATCH_SET: assert property (
        @(posedge clock) disable iff (sys_rst)
        $rose(status_reg_one[1]) |->
        !$past(status_reg_one[0]) && cs_n && $past(cs_n, 2))
        else $error("write latch set while busy or selected");
    AST_LOCK_STICKY: assert property (
        @(posedge clock) disable iff (sys_rst)
        !$past(soft_reset) && !$past(soft_reset, 2) |->
        ($past(status_reg_two) & ~status_reg_two & 8'h38) == 8'h00)
        else $error("security lock cleared");
    AST_RO_BITS: assert property (
        @(posedge clock) disable iff (sys_rst)
        $stable(status_reg_two & ~flash_cmd_pkg::TWO_WRITABLE) &&
        $stable(status_reg_three & ~flash_cmd_pkg::THREE_WRITABLE))
        else $error("read-only status bit changed");
endmodule : flash_cmds_checker
bind flash_status_read_cmds flash_cmds_checker #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .ARRAY_ADDR_WIDTH(ARRAY_ADDR_WIDTH)
) chk (
    .clock(clock), .sys_rst(sys_rst), .soft_reset(soft_reset),
    .four_wire_command_mode(four_wire_command_mode),
    .link_clk(link_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .array_addr(array_addr), .array_data(array_data),
    .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
    .status_reg_three(status_reg_three)
);
`default_nettype wire

// *** testbench/host_model.sv ***
// Host controller model: frames with chip select, link clock and data
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Serial link
    output logic cs_n,
    output logic link_clk,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out
);
    initial begin
        cs_n = 1'b1;
        link_clk = 1'b0;
        io_in = 4'h5;
    end
    ////////////////////////////////////////////////////////////////////////
    // Sends nt clocks from tx, then takes nr clocks; w lines a clock
    task automatic frame(input logic [63:0] tx, input int nt, input int nr,
                         input int w, output logic [63:0] rx);
        int i;
        rx = '0;
        cs_n = 1'b0;
        for (i = 0; i < nt + nr; i++) begin
            io_in = ~io_in;
            if (i < nt && w == 4) begin
                io_in = tx[4*(nt-1-i) +: 4];
            end else if (i < nt) begin
                io_in[0] = tx[nt-1-i];
            end
            #24 link_clk = 1'b1;
            if (i >= nt && w == 4) begin
                rx = {rx[59:0], io_out};
            end else if (i >= nt) begin
                rx = {rx[62:0], io_out[1]};
            end
            #24 link_clk = 1'b0;
        end
        cs_n = 1'b1;
        io_in = ~io_in;
    endtask : frame
endmodule : host_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the status and read command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, want, got) begin \
    total_checks++; \
    if ((got) !== (want)) begin \
        miscompares++; \
        $display("MISMATCH %s exp %h got %h", nm, want, got); \
    end \
end
module testbench;
    localparam int WC = 400;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] want;
    } row_s;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_reset = 1'b0;
    logic four_wire_command_mode = 1'b0;
    logic cs_n, link_clk;
    logic oe_seen = 1'b0;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] array_addr;
    logic [7:0] array_data, status_reg_one, status_reg_two, status_reg_three;
    logic [63:0] rx;
    int miscompares = 0;
    int total_checks = 0;
    row_s rows [5] = '{'{8'h06, 8'h02}, '{8'h04, 8'h00}, '{8'h50, 8'h00},
                       '{8'h06, 8'h02}, '{8'h04, 8'h00}};
    assign array_data = array_addr[7:0] ^ 8'ha5;
    always @(posedge link_clk) if (io_oe !== 4'h0) oe_seen = 1'b1;
    initial begin
        forever #5 clock = ~clock;
    end
    flash_status_read_cmds #(.WRITE_CYCLES(WC)) DUT (
        .clock(clock), .sys_rst(sys_rst), .soft_reset(soft_reset),
        .four_wire_command_mode(four_wire_command_mode),
        .link_clk(link_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .array_addr(array_addr), .array_data(array_data),
        .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
        .status_reg_three(status_reg_three)
    );
    host_model host (
        .cs_n(cs_n), .link_clk(link_clk), .io_in(io_in), .io_out(io_out)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic cmd(input logic [63:0] tx, input int nt, input int nr);
        host.frame(tx, nt, nr, four_wire_command_mode ? 4 : 1, rx);
        #100;
        @(negedge clock);
    endtask : cmd
    task automatic wait_idle;
        int k;
        for (k = 0; k < 1000 && status_reg_one[0] !== 1'b0; k++) begin
            @(negedge clock);
        end
        `CHK("idle", 1'b0, status_reg_one[0])
    endtask : wait_idle
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #300000;
        miscompares++;
        $display("MISMATCH watchdog exp done got hang");
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("r1", 8'h00, status_reg_one)
        `CHK("r3", 8'h60, status_reg_three)
        cmd(64'h15, 8, 16);
        `CHK("rd3", 16'h6060, rx[15:0])
        $display("reset test done");
        foreach (rows[i]) begin
            cmd({56'h0, rows[i].code}, 8, 0);
            cmd(64'h05, 8, 16);
            `CHK("rd1", {2{rows[i].want}}, rx[15:0])
            `CHK("r1", rows[i].want, status_reg_one)
            $display("row %0d done", i);
        end
        cmd(64'h06, 8, 0);
        cmd(64'h01ff, 16, 0);
        cmd(64'h05, 8, 8);
        `CHK("poll", 8'h03, rx[7:0])
        oe_seen = 1'b0;
        cmd(64'h03000010, 32, 8);
        `CHK("rdbusy", 1'b0, oe_seen)
        wait_idle();
        `CHK("nv", 8'hfc, status_reg_one)
        cmd(64'h0100, 16, 0);
        `CHK("nolatch", 8'hfc, status_reg_one)
        cmd(64'h06, 8, 0);
        cmd(64'h010cff, 24, 0);
        wait_idle();
        `CHK("two1", 8'h0c, status_reg_one)
        cmd(64'h35, 8, 8);
        `CHK("rd2", 8'h7b, rx[7:0])
        cmd(64'h06, 8, 0);
        cmd(64'h0100, 16, 0);
        wait_idle();
        `CHK("one1", 8'h00, status_reg_one)
        `CHK("one2", 8'h7b, status_reg_two)
        cmd(64'h06, 8, 0);
        cmd(64'h3100, 16, 0);
        wait_idle();
        `CHK("locks", 8'h38, status_reg_two)
        $display("write test done");
        cmd(64'h50, 8, 0);
        cmd(64'h11ff, 16, 0);
        `CHK("v3", 8'he4, status_reg_three)
        `CHK("v1", 8'h00, status_reg_one)
        cmd(64'h50, 8, 0);
        cmd(64'h3101, 16, 0);
        cmd(64'h50, 8, 0);
        cmd(64'h3100, 16, 0);
        `CHK("vlock", 8'h39, status_reg_two)
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("rl3", 8'h60, status_reg_three)
        `CHK("rl2", 8'h38, status_reg_two)
        cmd(64'h03000010, 32, 24);
        `CHK("array", 24'hb5b4b7, rx[23:0])
        $display("volatile and read test done");
        four_wire_command_mode = 1'b1;
        repeat (4) @(negedge clock);
        // Partial frame: two link clocks carry the new mode across
        cmd(64'h0, 2, 0);
        cmd(64'h15, 2, 4);
        `CHK("q3", 16'h6060, rx[15:0])
        oe_seen = 1'b0;
        cmd(64'h03, 2, 10);
        `CHK("qread", 1'b0, oe_seen)
        cmd(64'h50, 2, 0);
        cmd(64'h3102, 4, 0);
        `CHK("qe", 8'h38, status_reg_two)
        $display("four-wire test done");
        sys_rst = 1'b1;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("rst2", 8'h00, status_reg_two)
        $display("second reset test done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
